// ==== shared/intc_pkg.sv ====
// Shared constants, dispatch kinds and vector decoding for the interrupt unit.
// Assumes a single core clock; slot numbers equal the default priority order.
package intc_pkg;

  // Source census: all sources, and those whose handling mode software selects
  localparam int NUM_SOURCES = 30;
  localparam int NUM_SELECTABLE = 26;

  localparam int NUM_SLOTS = 24;
  localparam int SLOT_W = 5;
  localparam int LEVEL_W = 2;
  localparam int NUM_LEVELS = 4;
  localparam int BANK_W = 3;
  localparam int MSC_W = 8;
  localparam int ADDR_W = 16;
  localparam int NUM_MISC = 13;

  localparam logic [MSC_W-1:0] MSC_RESET = 8'h00;
  localparam logic [MSC_W-1:0] MSC_ONE = 8'h01;

  localparam logic [ADDR_W-1:0] VEC_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] VEC_NMI = 16'h0002;
  localparam logic [ADDR_W-1:0] VEC_OPERAND_TRAP = 16'h003c;
  localparam logic [ADDR_W-1:0] VEC_BREAK = 16'h003e;
  localparam logic [ADDR_W-1:0] VEC_NONE = 16'h0000;
  localparam logic [ADDR_W-1:0] MACRO_WORD_BASE = 16'hfe00;

  // Slots of the named sources (slot = default priority)
  localparam logic [SLOT_W-1:0] SLOT_PIN_EDGE0 = 5'h00;
  localparam logic [SLOT_W-1:0] SLOT_CAPTURE_THREE = 5'h01;
  localparam logic [SLOT_W-1:0] SLOT_CAPTURE_TWO = 5'h02;
  localparam logic [SLOT_W-1:0] SLOT_CAPTURE_ONE = 5'h0a;
  localparam logic [SLOT_W-1:0] SLOT_CONVERSION = 5'h0d;
  localparam logic [SLOT_W-1:0] SLOT_PIN2_TIMER4 = 5'h0e;
  localparam logic [SLOT_W-1:0] SLOT_SERIAL1 = 5'h13;
  localparam logic [SLOT_W-1:0] SLOT_WATCH = 5'h14;
  localparam logic [SLOT_W-1:0] SLOT_PIN_EDGE1 = 5'h15;
  localparam logic [SLOT_W-1:0] SLOT_PIN_EDGE3 = 5'h16;
  localparam logic [SLOT_W-1:0] SLOT_SERIAL2 = 5'h17;

  typedef enum logic [2:0] {
    KIND_RESET,
    KIND_NMI,
    KIND_VECTOR,
    KIND_CONTEXT,
    KIND_TRAP,
    KIND_BREAK,
    KIND_BANK_BREAK
  } dispatch_kind_t;

  // Vector table entry of a maskable slot
  function automatic logic [ADDR_W-1:0] vector_of(input logic [SLOT_W-1:0] slot);
    case (slot)
      5'h00: vector_of = 16'h0006;
      5'h01: vector_of = 16'h0008;
      5'h02: vector_of = 16'h000a;
      5'h03: vector_of = 16'h000c;
      5'h04: vector_of = 16'h000e;
      5'h05: vector_of = 16'h0010;
      5'h06: vector_of = 16'h0012;
      5'h07: vector_of = 16'h0014;
      5'h08: vector_of = 16'h0016;
      5'h09: vector_of = 16'h0018;
      5'h0a: vector_of = 16'h001a;
      5'h0b: vector_of = 16'h001c;
      5'h0c: vector_of = 16'h0020;
      5'h0d: vector_of = 16'h0022;
      5'h0e: vector_of = 16'h0024;
      5'h0f: vector_of = 16'h0026;
      5'h10: vector_of = 16'h0028;
      5'h11: vector_of = 16'h002a;
      5'h12: vector_of = 16'h002c;
      5'h13: vector_of = 16'h002e;
      5'h14: vector_of = 16'h0030;
      5'h15: vector_of = 16'h0034;
      5'h16: vector_of = 16'h0036;
      5'h17: vector_of = 16'h003a;
      default: vector_of = VEC_NONE;
    endcase
  endfunction

  // Control word sits in the high page at the vector's low byte
  function automatic logic [ADDR_W-1:0] macro_word_of(input logic [SLOT_W-1:0] slot);
    logic [ADDR_W-1:0] vec;
    vec = vector_of(slot);
    macro_word_of = MACRO_WORD_BASE | {8'h00, vec[7:0]};
  endfunction

endpackage

// ==== verilog/priority_picker.sv ====
// Picks the winning pending maskable slot by programmed level, then slot.
// Assumes requests are already masked; purely combinational.
`timescale 1ns/100ps
module priority_picker
  import intc_pkg::*;
(
  input wire logic [NUM_SLOTS-1:0] req,
  input wire logic [NUM_SLOTS*LEVEL_W-1:0] level,
  output logic found,
  output logic [SLOT_W-1:0] slot
);

  logic [LEVEL_W-1:0] best;

  always_comb begin
    found = 1'b0;
    slot = '0;
    best = '1;
    // Ascending scan with strict compare keeps the lower slot on a tie
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (req[i] && (!found || level[i*LEVEL_W +: LEVEL_W] < best)) begin
        found = 1'b1;
        slot = SLOT_W'(i);
        best = level[i*LEVEL_W +: LEVEL_W];
      end
    end
  end

endmodule

// ==== verilog/macro_count_store.sv ====
// Per-slot macro service counts with a write port and a decrement port.
// Assumes write and decrement never occur in the same cycle, whatever the slots;
// the write wins and the decrement is dropped if they do.
`timescale 1ns/100ps
module macro_count_store
  import intc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [SLOT_W-1:0] wr_slot,
  input wire logic [MSC_W-1:0] wr_data,
  input wire logic dec_en,
  input wire logic [SLOT_W-1:0] dec_slot,
  output logic [MSC_W-1:0] rd_count
);

  logic [MSC_W-1:0] count [NUM_SLOTS];

  assign rd_count = count[dec_slot];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        count[i] <= MSC_RESET;
      end
    end else if (wr_en) begin
      count[wr_slot] <= wr_data;
    end else if (dec_en) begin
      count[dec_slot] <= count[dec_slot] - MSC_ONE;
    end
  end

endmodule

// ==== verilog/interrupt_and_macro_service.sv ====
// Interrupt acceptance, arbitration and dispatch with counter-mode macro service.
// Assumes one-cycle request pulses synchronous to core_clk, and a CPU that
// takes a dispatch by raising dispatch_ready at an instruction boundary.
`timescale 1ns/100ps

// Contract
// - Thirty sources accepted; twenty-six may use context switching or macro service; the code gives that choice to 25 sources in 24 slots.
// - Pin edge zero: priority 0, vector 0006H, control word FE06H.
// - Capture three from pulse-width detector: priority 1, vector 0008H.
// - Capture two from drum speed input edge: priority 2, vector 000AH.
// - Capture one: priority 10, vector 001AH, control word FE1AH.
// - Conversion done: priority 13, vector 0022H, control word FE22H.
// - Pin edge two and timer four compare share priority 14, 0024H, FE24H.
// - Serial channel one done: priority 19, vector 002EH, word FE2EH.
// - Watch overflow: priority 20, vector 0030H, control word FE30H.
// - Pin edges one and three: priorities 21, 22; vectors 0034H, 0036H.
// - Serial channel two done: lowest priority 23, vector 003AH.
// - Illegal operand traps through 003CH, always vectored, no macro or bank.
// - Software break instruction branches through 003EH.
// - Vectored dispatch uses table address; four programmable levels per source.
// - Context request or bank break selects bank, branches to bank-held address.
// - Context switch saves PC and status word into the bank, not stack.
// - Macro service updates counts without CPU, saving no CPU state.
// - Counter mode decrements the source's count by one per request.
// - Count reaching zero turns the request into a vectored interrupt.
module interrupt_and_macro_service
  import intc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic nmi_pin,
  input wire logic pin_edge_req0,
  input wire logic pin_edge_req1,
  input wire logic pin_edge_req2,
  input wire logic pin_edge_req3,
  input wire logic capture_one_req,
  input wire logic capture_two_req,
  input wire logic capture_three_req,
  input wire logic timer4_compare_req,
  input wire logic conversion_done_req,
  input wire logic serial_ch1_done_req,
  input wire logic serial_ch2_done_req,
  input wire logic watch_overflow_req,
  input wire logic [NUM_MISC-1:0] misc_req,
  input wire logic operand_error_trap,
  input wire logic software_break_instr,
  input wire logic bank_switch_break_instr,
  input wire logic [BANK_W-1:0] bank_switch_break_bank,
  input wire logic int_enable,
  input wire logic [NUM_SLOTS-1:0] slot_mask,
  input wire logic [NUM_SLOTS*LEVEL_W-1:0] slot_level,
  input wire logic [NUM_SLOTS-1:0] slot_context_en,
  input wire logic [NUM_SLOTS-1:0] slot_macro_en,
  input wire logic [NUM_SLOTS*BANK_W-1:0] slot_bank,
  input wire logic msc_wr_en,
  input wire logic [SLOT_W-1:0] msc_wr_slot,
  input wire logic [MSC_W-1:0] msc_wr_data,
  input wire logic dispatch_ready,
  output logic dispatch_valid,
  output dispatch_kind_t dispatch_kind,
  output logic [ADDR_W-1:0] dispatch_vector,
  output logic [BANK_W-1:0] dispatch_bank,
  output logic dispatch_save_to_bank,
  output logic [SLOT_W-1:0] dispatch_slot,
  output logic [LEVEL_W-1:0] dispatch_level,
  output logic macro_busy,
  output logic [ADDR_W-1:0] macro_word_addr,
  output logic macro_count_zero,
  output logic [NUM_SLOTS-1:0] pending
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MACRO,
    ST_DISPATCH
  } state_t;

  logic rst_sync1;
  logic rst_n;
  state_t state;
  state_t next_state;
  logic reset_vector_due;
  logic nmi_last;
  logic nmi_pending;
  logic trap_pending;
  logic brk_pending;
  logic bank_switch_break_instr_pending;
  logic [BANK_W-1:0] bank_switch_break_instr_bank;
  logic [NUM_SLOTS-1:0] macro_spent;
  logic [SLOT_W-1:0] macro_slot;

  // Internal reset: asynchronous assert, two-stage synchronous release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // Request slot map; pin edge two and timer four compare share one slot
  wire [NUM_SLOTS-1:0] slot_req;
  assign slot_req[SLOT_PIN_EDGE0] = pin_edge_req0;
  assign slot_req[SLOT_CAPTURE_THREE] = capture_three_req;
  assign slot_req[SLOT_CAPTURE_TWO] = capture_two_req;
  assign slot_req[9:3] = misc_req[6:0];
  assign slot_req[SLOT_CAPTURE_ONE] = capture_one_req;
  assign slot_req[12:11] = misc_req[8:7];
  assign slot_req[SLOT_CONVERSION] = conversion_done_req;
  assign slot_req[SLOT_PIN2_TIMER4] = pin_edge_req2 | timer4_compare_req;
  assign slot_req[18:15] = misc_req[12:9];
  assign slot_req[SLOT_SERIAL1] = serial_ch1_done_req;
  assign slot_req[SLOT_WATCH] = watch_overflow_req;
  assign slot_req[SLOT_PIN_EDGE1] = pin_edge_req1;
  assign slot_req[SLOT_PIN_EDGE3] = pin_edge_req3;
  assign slot_req[SLOT_SERIAL2] = serial_ch2_done_req;

  wire nmi_edge = nmi_pin & ~nmi_last;
  wire [NUM_SLOTS-1:0] eligible = pending & ~slot_mask & {NUM_SLOTS{int_enable}};
  wire pick_found;
  wire [SLOT_W-1:0] pick_slot;

  priority_picker u_picker (
    .req(eligible),
    .level(slot_level),
    .found(pick_found),
    .slot(pick_slot)
  );

  // Fixed-order choice among non-maskable kinds ahead of maskable ones
  wire take_reset = (state == ST_IDLE) && reset_vector_due;
  wire take_nmi = (state == ST_IDLE) && !reset_vector_due && nmi_pending;
  wire take_trap = (state == ST_IDLE) && !reset_vector_due && !nmi_pending && trap_pending;
  wire special_busy = reset_vector_due | nmi_pending | trap_pending;
  wire take_brk = (state == ST_IDLE) && !special_busy && brk_pending;
  wire take_bank_switch_break_instr = (state == ST_IDLE) && !special_busy && !brk_pending && bank_switch_break_instr_pending;
  wire any_break = brk_pending | bank_switch_break_instr_pending;
  wire take_mask = (state == ST_IDLE) && !special_busy && !any_break && pick_found;
  wire pick_macro = slot_macro_en[pick_slot] && !macro_spent[pick_slot];
  wire pick_context = slot_context_en[pick_slot];
  wire take_macro = take_mask && pick_macro;
  wire take_vectored = take_mask && !pick_macro;
  wire [BANK_W-1:0] pick_bank = slot_bank[pick_slot*BANK_W +: BANK_W];
  wire [LEVEL_W-1:0] pick_level = slot_level[pick_slot*LEVEL_W +: LEVEL_W];
  wire [MSC_W-1:0] macro_count;
  wire macro_dec = (state == ST_MACRO);
  wire count_hits_zero = macro_dec && (macro_count == MSC_ONE);
  wire dispatch_done = (state == ST_DISPATCH) && dispatch_ready;

  macro_count_store u_counts (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(msc_wr_en),
    .wr_slot(msc_wr_slot),
    .wr_data(msc_wr_data),
    .dec_en(macro_dec),
    .dec_slot(macro_slot),
    .rd_count(macro_count)
  );

  // A request landing in its acknowledge cycle stays pending
  wire [NUM_SLOTS-1:0] ack_clear = (take_mask ? (NUM_SLOTS'(1) << pick_slot) : '0);
  wire [NUM_SLOTS-1:0] spent_set = (count_hits_zero ? (NUM_SLOTS'(1) << macro_slot) : '0);
  wire [NUM_SLOTS-1:0] spent_clr = (msc_wr_en ? (NUM_SLOTS'(1) << msc_wr_slot) : '0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= '0;
      macro_spent <= '0;
    end else begin
      pending <= slot_req | (pending & ~ack_clear);
      macro_spent <= spent_set | (macro_spent & ~spent_clr);
    end
  end

  // Event flags: a new event in the taking cycle wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_vector_due <= 1'b1;
      nmi_last <= 1'b0;
      nmi_pending <= 1'b0;
      trap_pending <= 1'b0;
      brk_pending <= 1'b0;
      bank_switch_break_instr_pending <= 1'b0;
    end else begin
      reset_vector_due <= reset_vector_due & ~take_reset;
      nmi_last <= nmi_pin;
      nmi_pending <= nmi_edge | (nmi_pending & ~take_nmi);
      trap_pending <= operand_error_trap | (trap_pending & ~take_trap);
      brk_pending <= software_break_instr | (brk_pending & ~take_brk);
      bank_switch_break_instr_pending <= bank_switch_break_instr | (bank_switch_break_instr_pending & ~take_bank_switch_break_instr);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_switch_break_instr_bank <= '0;
    end else if (bank_switch_break_instr) begin
      bank_switch_break_instr_bank <= bank_switch_break_bank;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_macro) begin
          next_state = ST_MACRO;
        end else if (take_reset | take_nmi | take_trap | take_brk | take_bank_switch_break_instr | take_vectored) begin
          next_state = ST_DISPATCH;
        end
      end
      ST_MACRO: begin
        // The CPU is never involved unless the count runs out
        next_state = count_hits_zero ? ST_DISPATCH : ST_IDLE;
      end
      ST_DISPATCH: begin
        if (dispatch_ready) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign dispatch_valid = (state == ST_DISPATCH);
  assign macro_busy = (state == ST_MACRO);

  // Macro engine bookkeeping
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      macro_slot <= '0;
      macro_word_addr <= VEC_NONE;
      macro_count_zero <= 1'b0;
    end else begin
      macro_count_zero <= count_hits_zero;
      if (take_macro) begin
        macro_slot <= pick_slot;
        macro_word_addr <= macro_word_of(pick_slot);
      end
    end
  end

  // Dispatch record, held stable while the CPU has not taken it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dispatch_kind <= KIND_RESET;
      dispatch_vector <= VEC_RESET;
      dispatch_bank <= '0;
      dispatch_save_to_bank <= 1'b0;
      dispatch_slot <= '0;
      dispatch_level <= '0;
    end else if (take_reset) begin
      dispatch_kind <= KIND_RESET;
      dispatch_vector <= VEC_RESET;
      dispatch_save_to_bank <= 1'b0;
    end else if (take_nmi) begin
      dispatch_kind <= KIND_NMI;
      dispatch_vector <= VEC_NMI;
      dispatch_save_to_bank <= 1'b0;
    end else if (take_trap) begin
      dispatch_kind <= KIND_TRAP;
      dispatch_vector <= VEC_OPERAND_TRAP;
      dispatch_save_to_bank <= 1'b0;
    end else if (take_brk) begin
      dispatch_kind <= KIND_BREAK;
      dispatch_vector <= VEC_BREAK;
      dispatch_save_to_bank <= 1'b0;
    end else if (take_bank_switch_break_instr) begin
      dispatch_kind <= KIND_BANK_BREAK;
      dispatch_vector <= VEC_BREAK;
      dispatch_bank <= bank_switch_break_instr_bank;
      dispatch_save_to_bank <= 1'b1;
    end else if (take_vectored) begin
      dispatch_slot <= pick_slot;
      dispatch_level <= pick_level;
      dispatch_vector <= vector_of(pick_slot);
      if (pick_context) begin
        dispatch_kind <= KIND_CONTEXT;
        dispatch_bank <= pick_bank;
        dispatch_save_to_bank <= 1'b1;
      end else begin
        dispatch_kind <= KIND_VECTOR;
        dispatch_save_to_bank <= 1'b0;
      end
    end else if (count_hits_zero) begin
      // Exhausted count always ends in a plain vectored branch
      dispatch_kind <= KIND_VECTOR;
      dispatch_slot <= macro_slot;
      dispatch_level <= slot_level[macro_slot*LEVEL_W +: LEVEL_W];
      dispatch_vector <= vector_of(macro_slot);
      dispatch_save_to_bank <= 1'b0;
    end else if (dispatch_done) begin
      dispatch_save_to_bank <= 1'b0;
    end
  end

endmodule

// ==== tb/intc_properties.sv ====
// Checker for the dispatch and macro outputs of the interrupt unit.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module intc_properties
  import intc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic dispatch_ready,
  input wire logic dispatch_valid,
  input wire dispatch_kind_t dispatch_kind,
  input wire logic [ADDR_W-1:0] dispatch_vector,
  input wire logic dispatch_save_to_bank,
  input wire logic [SLOT_W-1:0] dispatch_slot,
  input wire logic macro_busy,
  input wire logic [ADDR_W-1:0] macro_word_addr,
  input wire logic macro_count_zero
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire vec_out = dispatch_valid && dispatch_kind == KIND_VECTOR;

  hold_until_taken_a: assert property (dispatch_valid && !dispatch_ready |=>
    dispatch_valid && $stable(dispatch_vector) && $stable(dispatch_kind))
    else $error("dispatch changed before it was taken");
  one_idle_gap_a: assert property (dispatch_valid && dispatch_ready |=> !dispatch_valid)
    else $error("dispatch shown again without an idle cycle");
  trap_vector_a: assert property (dispatch_valid && dispatch_kind == KIND_TRAP |->
    dispatch_vector == VEC_OPERAND_TRAP && !dispatch_save_to_bank)
    else $error("operand trap with wrong vector or bank save");
  break_vector_a: assert property (dispatch_valid && dispatch_kind == KIND_BREAK |->
    dispatch_vector == VEC_BREAK)
    else $error("break with wrong vector");
  bank_save_a: assert property (dispatch_valid && (dispatch_kind == KIND_CONTEXT ||
    dispatch_kind == KIND_BANK_BREAK) |-> dispatch_save_to_bank)
    else $error("context dispatch without bank save");
  vector_stack_a: assert property (vec_out |-> !dispatch_save_to_bank)
    else $error("vectored dispatch saving to bank");
  macro_silent_a: assert property (macro_busy |-> !dispatch_valid ##1
    macro_word_addr[15:8] == 8'hfe)
    else $error("macro step disturbed the CPU or missed its control word");
  zero_to_vector_a: assert property (macro_count_zero |-> vec_out && $past(macro_busy))
    else $error("exhausted count not turned into vectored dispatch");
  top_slot_a: assert property (vec_out && dispatch_slot == SLOT_PIN_EDGE0 |->
    dispatch_vector == 16'h0006)
    else $error("slot zero vector wrong");
  last_slot_a: assert property (vec_out && dispatch_slot == SLOT_SERIAL2 |->
    dispatch_vector == 16'h003a)
    else $error("lowest slot vector wrong");

  reset_seen_c: cover property (dispatch_valid && dispatch_kind == KIND_RESET);
  zero_seen_c: cover property (macro_count_zero);
  ctx_seen_c: cover property (dispatch_valid && dispatch_kind == KIND_CONTEXT);
endmodule

bind interrupt_and_macro_service intc_properties chk (.core_clk, .resetn, .dispatch_ready,
  .dispatch_valid, .dispatch_kind, .dispatch_vector, .dispatch_save_to_bank, .dispatch_slot,
  .macro_busy, .macro_word_addr, .macro_count_zero);

// ==== tb/cpu_model.sv ====
// CPU side model: takes each dispatch after a programmable number of cycles.
// Assumes the unit holds its dispatch outputs until dispatch_ready is seen.
`timescale 1ns/100ps
module cpu_model (
  input wire logic core_clk,
  input wire logic dispatch_valid,
  input wire logic [3:0] hold_cycles,
  output logic dispatch_ready
);
  logic [3:0] waited;
  initial begin
    dispatch_ready = 1'b0;
    waited = 4'h0;
  end
  // Ready only rises while a dispatch is shown, so nothing is taken early
  always @(posedge core_clk) begin
    if (dispatch_valid && dispatch_ready) begin
      dispatch_ready <= 1'b0;
      waited <= 4'h0;
    end else if (dispatch_valid) begin
      waited <= waited + 4'h1;
      dispatch_ready <= (waited >= hold_cycles);
    end
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the interrupt unit with a CPU model on dispatch.
// Assumes the package constants and a 40 MHz core clock.
`timescale 1ns/100ps
module tb;
  import intc_pkg::*;
  logic core_clk, resetn, nmi_pin, operand_error_trap, software_break_instr;
  logic bank_switch_break_instr, int_enable, msc_wr_en, dispatch_ready;
  logic [24:0] src;
  logic [BANK_W-1:0] bank_switch_break_bank, dispatch_bank;
  logic [NUM_SLOTS-1:0] slot_mask, slot_context_en, slot_macro_en, pending;
  logic [NUM_SLOTS*LEVEL_W-1:0] slot_level;
  logic [NUM_SLOTS*BANK_W-1:0] slot_bank;
  logic [SLOT_W-1:0] msc_wr_slot, dispatch_slot;
  logic [MSC_W-1:0] msc_wr_data;
  logic [3:0] hold_cycles;
  logic dispatch_valid, dispatch_save_to_bank, macro_busy, macro_count_zero;
  dispatch_kind_t dispatch_kind;
  logic [ADDR_W-1:0] dispatch_vector, macro_word_addr;
  logic [LEVEL_W-1:0] dispatch_level;
  int fail_count, checks, cycles;
  // Last entry is a misc source (bit 7 of misc_req)
  logic [15:0] vecs [13] = '{16'h0006, 16'h0008, 16'h000a, 16'h001a, 16'h0022, 16'h0024,
    16'h0024, 16'h002e, 16'h0030, 16'h0034, 16'h0036, 16'h003a, 16'h001c};
  logic [4:0] slots [13] = '{5'h00, 5'h01, 5'h02, 5'h0a, 5'h0d, 5'h0e, 5'h0e, 5'h13, 5'h14,
    5'h15, 5'h16, 5'h17, 5'h0b};

  interrupt_and_macro_service uut (
    .core_clk, .resetn, .nmi_pin,
    .pin_edge_req0(src[0]), .capture_three_req(src[1]), .capture_two_req(src[2]),
    .capture_one_req(src[3]), .conversion_done_req(src[4]), .pin_edge_req2(src[5]),
    .timer4_compare_req(src[6]), .serial_ch1_done_req(src[7]), .watch_overflow_req(src[8]),
    .pin_edge_req1(src[9]), .pin_edge_req3(src[10]), .serial_ch2_done_req(src[11]),
    .misc_req(src[24:12]), .operand_error_trap, .software_break_instr,
    .bank_switch_break_instr, .bank_switch_break_bank, .int_enable, .slot_mask,
    .slot_level, .slot_context_en, .slot_macro_en, .slot_bank, .msc_wr_en, .msc_wr_slot,
    .msc_wr_data, .dispatch_ready, .dispatch_valid, .dispatch_kind, .dispatch_vector,
    .dispatch_bank, .dispatch_save_to_bank, .dispatch_slot, .dispatch_level, .macro_busy,
    .macro_word_addr, .macro_count_zero, .pending);

  cpu_model cpu (.core_clk, .dispatch_valid, .hold_cycles, .dispatch_ready);

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Requests last exactly one cycle; longer levels would re-arm pending
  task automatic pulse(input logic [24:0] s, input logic [2:0] tbn);
    @(negedge core_clk);
    src = s;
    {operand_error_trap, software_break_instr, nmi_pin} = tbn;
    @(negedge core_clk);
    src = 25'h000_0000;
    {operand_error_trap, software_break_instr, nmi_pin} = 3'h0;
  endtask

  // Returns while the dispatch is still shown, so callers may inspect it
  task automatic exp_disp(input dispatch_kind_t k, input logic [15:0] v);
    int n;
    n = 0;
    while (dispatch_valid !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    // Kind and vector may linger from an earlier dispatch, so presence is checked too
    check("valid", 16'h0001, 16'(dispatch_valid));
    check("kind", 16'(k), 16'(dispatch_kind));
    check("vector", v, dispatch_vector);
  endtask

  task automatic settle();
    int n;
    n = 0;
    while (dispatch_valid === 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic wait_busy();
    int n;
    n = 0;
    while (macro_busy !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check("macro_busy", 16'h0001, 16'(macro_busy));
    @(negedge core_clk);
  endtask

  task automatic t_reset();
    exp_disp(KIND_RESET, VEC_RESET);
    settle();
    $display("test reset done");
  endtask

  task automatic t_table();
    for (int i = 0; i < 13; i++) begin
      pulse(25'h000_0001 << ((i == 12) ? 19 : i), 3'h0);
      exp_disp(KIND_VECTOR, vecs[i]);
      check("slot", 16'(slots[i]), 16'(dispatch_slot));
      settle();
    end
    $display("test table done");
  endtask

  // Slot 2 and slot 23 tie on level 1, slot 0 sits lower at level 2
  task automatic t_priority();
    hold_cycles = 4'h4;
    slot_level[5:4] = 2'h1;
    slot_level[47:46] = 2'h1;
    slot_level[1:0] = 2'h2;
    pulse(25'h000_0805, 3'h0);
    exp_disp(KIND_VECTOR, 16'h000a);
    check("level", 16'h0001, 16'(dispatch_level));
    settle();
    exp_disp(KIND_VECTOR, 16'h003a);
    settle();
    exp_disp(KIND_VECTOR, 16'h0006);
    settle();
    slot_level = '0;
    hold_cycles = 4'h0;
    $display("test priority done");
  endtask

  task automatic t_fixed();
    pulse(25'h000_0001, 3'h7);
    exp_disp(KIND_NMI, VEC_NMI);
    settle();
    exp_disp(KIND_TRAP, VEC_OPERAND_TRAP);
    settle();
    exp_disp(KIND_BREAK, VEC_BREAK);
    settle();
    exp_disp(KIND_VECTOR, 16'h0006);
    settle();
    @(negedge core_clk);
    bank_switch_break_instr = 1'b1;
    bank_switch_break_bank = 3'h3;
    @(negedge core_clk);
    bank_switch_break_instr = 1'b0;
    exp_disp(KIND_BANK_BREAK, VEC_BREAK);
    check("bank", 16'h0003, 16'(dispatch_bank));
    check("save", 16'h0001, 16'(dispatch_save_to_bank));
    settle();
    $display("test fixed done");
  endtask

  task automatic t_mask();
    slot_mask[0] = 1'b1;
    pulse(25'h000_0001, 3'h0);
    repeat (6) @(negedge core_clk);
    check("pending", 16'h0001, 16'(pending[0]));
    check("valid", 16'h0000, 16'(dispatch_valid));
    int_enable = 1'b0;
    slot_mask = '0;
    repeat (4) @(negedge core_clk);
    check("valid", 16'h0000, 16'(dispatch_valid));
    int_enable = 1'b1;
    exp_disp(KIND_VECTOR, 16'h0006);
    settle();
    $display("test mask done");
  endtask

  task automatic t_context();
    slot_context_en[13] = 1'b1;
    slot_bank[41:39] = 3'h5;
    pulse(25'h000_0010, 3'h0);
    exp_disp(KIND_CONTEXT, 16'h0022);
    check("bank", 16'h0005, 16'(dispatch_bank));
    check("save", 16'h0001, 16'(dispatch_save_to_bank));
    settle();
    slot_context_en = '0;
    $display("test context done");
  endtask

  task automatic t_macro();
    slot_macro_en[19] = 1'b1;
    @(negedge core_clk);
    {msc_wr_en, msc_wr_slot, msc_wr_data} = {1'b1, 5'h13, 8'h02};
    @(negedge core_clk);
    msc_wr_en = 1'b0;
    pulse(25'h000_0080, 3'h0);
    wait_busy();
    check("word", 16'hfe2e, macro_word_addr);
    check("valid", 16'h0000, 16'(dispatch_valid));
    pulse(25'h000_0080, 3'h0);
    wait_busy();
    check("zero", 16'h0001, 16'(macro_count_zero));
    exp_disp(KIND_VECTOR, 16'h002e);
    check("slot", 16'(SLOT_SERIAL1), 16'(dispatch_slot));
    settle();
    pulse(25'h000_0080, 3'h0);
    exp_disp(KIND_VECTOR, 16'h002e);
    settle();
    slot_macro_en = '0;
    $display("test macro done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Whole run needs about 150 cycles; the ceiling of 3000 leaves wide margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    {resetn, nmi_pin, operand_error_trap, software_break_instr} = 4'h0;
    {bank_switch_break_instr, msc_wr_en, int_enable} = 3'h1;
    {src, bank_switch_break_bank, msc_wr_slot, msc_wr_data, hold_cycles} = '0;
    {slot_mask, slot_context_en, slot_macro_en, slot_level, slot_bank} = '0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    t_reset();
    t_table();
    t_priority();
    t_fixed();
    t_mask();
    t_context();
    t_macro();
    report_and_stop();
  end
endmodule
